// ### src/mono_astable_pulse_control.v
// monostable / astable pulse control with clock-count timing
`timescale 1ns/1ps
`default_nettype none
`include "pulse_ctrl_consts.vh"
module mono_astable_pulse_control #(
  parameter CNT_W        = `CNT_W,
  parameter PULSE_CYCLES = `PULSE_CYCLES,
  parameter HALF_CYCLES  = `HALF_CYCLES
) (
  input  wire clk,
  input  wire arst_n,
  input  wire astable_run_hi,
  input  wire astable_run_n,
  input  wire rise_trigger,
  input  wire fall_trigger_n,
  input  wire retrigger_in,
  input  wire master_clear,
  output wire q_out,
  output wire q_out_n,
  output reg  osc_out
);
  // terminal counts; a count of zero is clamped so it behaves as one
  localparam integer PULSE_LAST_I = (PULSE_CYCLES > 1) ? PULSE_CYCLES - 1 : 0;
  localparam integer HALF_LAST_I  = (HALF_CYCLES > 1) ? HALF_CYCLES - 1 : 0;
  // quarter period for the double-rate tap; odd half periods skew its duty
  localparam integer QUART_LAST_I = (HALF_CYCLES / 2 > 0) ? HALF_CYCLES / 2 - 1 : 0;

  localparam [CNT_W-1:0] PULSE_LAST = PULSE_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] HALF_LAST  = HALF_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] QUART_LAST = QUART_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ZERO   = {CNT_W{1'b0}};

  // operating modes, decoded fresh every cycle
  localparam [1:0] MODE_IDLE    = 2'b00;
  localparam [1:0] MODE_PULSE   = 2'b01;
  localparam [1:0] MODE_ASTABLE = 2'b10;
  localparam [1:0] MODE_CLEAR   = 2'b11;

  reg             rst_s1_reg;
  reg             rst_s2_reg;
  reg             rise_d_reg;
  reg             fall_d_reg;
  reg             retrig_d_reg;
  reg             out_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg             out_next;
  reg [CNT_W-1:0] cnt_next;
  reg             osc_next;
  reg [1:0]       mode;
  wire            rst_n;
  wire            astable;
  wire            rise_edge;
  wire            fall_edge;
  wire            retrig_edge;
  wire            fire;
  wire            retrig;

  // counter step, shared by both timing modes
  function [CNT_W-1:0] count_up;
    input [CNT_W-1:0] value;
    begin
      count_up = value + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // terminal test; >= so a counter left high by a mode change still ends
  function at_last;
    input [CNT_W-1:0] value;
    input [CNT_W-1:0] last;
    begin
      at_last = (value >= last);
    end
  endfunction

  // low-to-high transition between two samples
  function rising;
    input cur;
    input prev;
    begin
      rising = cur & ~prev;
    end
  endfunction

  assign rst_n       = rst_s2_reg;
  assign astable     = astable_run_hi | ~astable_run_n;
  assign rise_edge   = rising(rise_trigger, rise_d_reg);
  assign fall_edge   = rising(fall_d_reg, fall_trigger_n);
  assign retrig_edge = rising(retrigger_in, retrig_d_reg);
  assign fire        = (rise_edge & ~fall_trigger_n) | (fall_edge & rise_trigger);
  assign retrig      = rise_edge & retrig_edge & ~fall_trigger_n;

  // release of arst_n is taken through two flops; assertion stays async
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // previous samples of the triggers; fall_n idles high so no false edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_d_reg   <= 1'b0;
      fall_d_reg   <= 1'b1;
      retrig_d_reg <= 1'b0;
    end else begin
      rise_d_reg   <= rise_trigger;
      fall_d_reg   <= fall_trigger_n;
      retrig_d_reg <= retrigger_in;
    end
  end

  always @* begin
    if (master_clear) begin
      mode = MODE_CLEAR;
    end else if (astable) begin
      mode = MODE_ASTABLE;
    end else if (out_reg) begin
      mode = MODE_PULSE;
    end else begin
      mode = MODE_IDLE;
    end
  end

  always @* begin
    out_next = out_reg;
    cnt_next = cnt_reg;
    osc_next = osc_out;
    case (mode)
      MODE_CLEAR: begin
        out_next = 1'b0;
        cnt_next = CNT_ZERO;
        osc_next = 1'b0;
      end
      MODE_ASTABLE: begin
        // triggers are ignored while free running
        if (at_last(cnt_reg, HALF_LAST)) begin
          cnt_next = CNT_ZERO;
          out_next = ~out_reg;
          osc_next = ~osc_out;
        end else begin
          cnt_next = count_up(cnt_reg);
          if (cnt_reg == QUART_LAST) begin
            osc_next = ~osc_out;
          end
        end
      end
      MODE_PULSE: begin
        osc_next = 1'b0;
        if (retrig) begin
          cnt_next = CNT_ZERO;
        end else if (at_last(cnt_reg, PULSE_LAST)) begin
          out_next = 1'b0;
          cnt_next = CNT_ZERO;
        end else begin
          cnt_next = count_up(cnt_reg);
        end
      end
      MODE_IDLE: begin
        osc_next = 1'b0;
        cnt_next = CNT_ZERO;
        if (fire) begin
          out_next = 1'b1;
        end
      end
      default: begin
        out_next = 1'b0;
        cnt_next = CNT_ZERO;
        osc_next = 1'b0;
      end
    endcase
  end

  // clear is an async override on the output flop and its timer
  always @(posedge clk or negedge rst_n or posedge master_clear) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
      cnt_reg <= CNT_ZERO;
      osc_out <= 1'b0;
    end else if (master_clear) begin
      out_reg <= 1'b0;
      cnt_reg <= CNT_ZERO;
      osc_out <= 1'b0;
    end else begin
      out_reg <= out_next;
      cnt_reg <= cnt_next;
      osc_out <= osc_next;
    end
  end

  assign q_out   = out_reg;
  assign q_out_n = ~out_reg;
endmodule
`default_nettype wire

// ### src/pulse_ctrl_consts.vh
// constants and contract of the monostable / astable pulse control block
// Contract
// - astable when run_hi high or run_n low
// - astable outputs square wave, 50 percent duty
// - oscillator output toggles at twice output rate
// - enables gate oscillation on and off
// - rising trigger edge fires if fall_n low
// - falling fall_n edge fires if rise high
// - pulse drives true high for set width
// - retrigger with rise edge restarts pulse timing
// - clear forces true low asynchronously, overriding all
// - outputs are complementary copies of one flop
`ifndef PULSE_CTRL_CONSTS_VH
`define PULSE_CTRL_CONSTS_VH
`define CLK_PERIOD_NS    50
`define PULSE_WIDTH_NS   10000
`define HALF_PERIOD_NS   5000
`define CNT_W            16
`define PULSE_CYCLES     (`PULSE_WIDTH_NS / `CLK_PERIOD_NS)
`define HALF_CYCLES      (`HALF_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// ### tb/drv.sv
// drives the block's controls
`timescale 1ns/1ps
`default_nettype none
module drv(input wire logic clk, output logic [5:0] c = 6'h10);
  task go(input logic [5:0] v); @(negedge clk) c = v; endtask
endmodule
`default_nettype wire

// ### tb/pulse_chk.sv
// port assertions for the pulse control
`timescale 1ns/1ps
`default_nettype none
module pulse_chk(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic astable_run_hi,
  input wire logic astable_run_n,
  input wire logic rise_trigger,
  input wire logic fall_trigger_n,
  input wire logic retrigger_in,
  input wire logic master_clear,
  input wire logic q_out,
  input wire logic q_out_n,
  input wire logic osc_out
);
  wire m = !astable_run_hi && astable_run_n && !master_clear;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_out_comp: assert property (q_out_n == !q_out) else $error("q_out_n");
  a_clear_low: assert property (master_clear |-> !q_out && !osc_out) else $error("clear");
  a_rise_fire: assert property (m && !q_out && $rose(rise_trigger) && !fall_trigger_n |=> q_out)
    else $error("rise");
  a_width_min: assert property (m && $rose(q_out) ##1 !master_clear[*7] |-> q_out) else $error("width");
  a_fall_fire: assert property (m && !q_out && $fell(fall_trigger_n) && rise_trigger |=> q_out)
    else $error("fall");
  a_retrig_ext: assert property (m && q_out && $rose(rise_trigger) && $rose(retrigger_in) && !fall_trigger_n
    ##1 m[*8] |-> q_out) else $error("retrigger");
  a_osc_with_q: assert property ($changed(q_out) && $past(astable_run_hi || !astable_run_n)
    && !master_clear && !$past(master_clear) |-> $changed(osc_out)) else $error("osc");
  a_mono_osc_low: assert property ($past(!astable_run_hi && astable_run_n) |-> !osc_out)
    else $error("osc idle");
  c_fire: cover property (m && $rose(q_out));
  c_osc: cover property ($rose(osc_out));
  c_clear: cover property (master_clear && $past(q_out));
endmodule
bind mono_astable_pulse_control pulse_chk pulse_chk_inst(.*);
`default_nettype wire

// ### tb/tb.sv
// bench for the pulse control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, arst_n = 0, q_out, q_out_n, osc_out;
  logic [5:0] c;
  integer n_fail = 0, compares = 0, seed = 32'h79762e92, cyc = 0, hi = 0, i;
  always #25 clk = ~clk;
  always @(posedge clk) hi += q_out;
  always @(posedge clk) if (++cyc > 3000) begin n_fail++; print_verdict; end
  drv drv_inst(.clk, .c);
  mono_astable_pulse_control #(.PULSE_CYCLES(8), .HALF_CYCLES(4)) mono_astable_pulse_control_inst(.clk, .arst_n,
    .astable_run_hi(c[5]), .astable_run_n(c[4]), .rise_trigger(c[3]), .fall_trigger_n(c[2]),
    .retrigger_in(c[1]), .master_clear(c[0]), .q_out, .q_out_n, .osc_out);
  function logic [7:0] wexp(input integer k); wexp = 8'(k + 10); endfunction
  task chk(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin n_fail++; $display("Error q_out high cycles exp %0d seen %0d", exp, seen); end
  endtask
  task print_verdict;
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task run(input logic [5:0] a, b, d, input integer k);
    @(negedge clk) hi = 0;
    drv_inst.go(6'h10); drv_inst.go(a); drv_inst.go(b);
    repeat (k) @(negedge clk);
    drv_inst.go(d);
    repeat (38) @(negedge clk);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1;
    run(6'h18, 6'h10, 6'h10, 0); chk(hi[7:0], 8'h08);
    run(6'h1c, 6'h18, 6'h18, 0); chk(hi[7:0], 8'h08);
    i = $unsigned($random(seed)) % 6;
    run(6'h18, 6'h10, 6'h1a, i); chk(hi[7:0], wexp(i));
    run(6'h30, 6'h30, 6'h30, 0); chk(hi[7:0], 8'h14);
    run(6'h00, 6'h00, 6'h00, 0); chk(hi[7:0], 8'h14);
    run(6'h18, 6'h10, 6'h11, 3); chk(hi[7:0], 8'h04);
    for (i = 0; i < 300; i++) drv_inst.go({2'b01, 3'($random(seed)), 1'b0});
    repeat (20) @(negedge clk);
    run(6'h10, 6'h10, 6'h10, 0); chk(hi[7:0], 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
